// ---- common/pmseq_pkg.sv ----
// Package with register map, defaults and types of the clock loop mode sequencer
package pmseq_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int INIT_TIME_US = 100;
	localparam int INIT_CYCLES = INIT_TIME_US * (CLK_HZ / 1_000_000);
	localparam int SAMPLE_PERIOD_MS = 1000;
	localparam int SAMPLE_CYC_DEF = SAMPLE_PERIOD_MS * (CLK_HZ / 1000);
	localparam int HIST_TIME_S = 120;
	localparam int HIST_DEPTH_DEF = HIST_TIME_S * 1000 / SAMPLE_PERIOD_MS;

	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_BW = 8'h04;
	localparam logic [7:0] OFS_INCFG = 8'h08;
	localparam logic [7:0] OFS_PRIO = 8'h0C;
	localparam logic [7:0] OFS_HOLD = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_HFREQ = 8'h18;

	localparam int B_HARD = 0;
	localparam int B_SOFT = 1;
	localparam int B_FAST = 2;
	localparam int B_REFEXT = 3;
	localparam int B_SELREG = 4;
	localparam int B_SELLO = 5;
	localparam int B_AUTO = 7;
	localparam int B_REVERT = 8;

	// Normal codes 0..9 span 0.1 Hz..100 Hz, fast codes 0..5 span 100 Hz..4 kHz
	localparam logic [3:0] NBW_MAX = 4'h9;
	localparam logic [2:0] FBW_MAX = 3'h5;
	localparam logic [2:0] WIN_LOG2_MAX = 3'h6;

	// Nonvolatile image restored by every hard reset; SYNC_RST is the pin synchronizer value loaded by RST_I only
	localparam logic [3:0] NVM_NBW = 4'h3;
	localparam logic [2:0] NVM_FBW = 3'h2;
	localparam logic NVM_FAST = 1'b1;
	localparam logic [3:0] NVM_IN_EN = 4'hF;
	localparam logic [3:0] NVM_IN_DIFF = 4'hF;
	localparam logic [7:0] NVM_PRIO = 8'hE4;
	localparam logic [2:0] NVM_WIN = 3'h3;
	localparam logic [6:0] NVM_DELAY = 7'h02;
	localparam logic [6:0] SYNC_RST = 7'h40;

	typedef enum logic [1:0] {ST_FREERUN, ST_ACQUIRE, ST_LOCKED, ST_HOLDOVER} pmseq_state_t;

	typedef struct packed {
		logic [3:0] nbw;
		logic [2:0] fbw;
		logic fast_en;
		logic ref_ext;
		logic [3:0] in_en;
		logic [3:0] in_diff;
	} pmseq_cfg_t;

	localparam pmseq_cfg_t NVM_CFG = '{NVM_NBW, NVM_FBW, NVM_FAST, 1'b0, NVM_IN_EN, NVM_IN_DIFF};
endpackage

// ---- rtl/pmseq_top.sv ----
// Mode sequencer of the clock synthesis loop with its APB register file
`timescale 1ns/100ps
module pmseq_top import pmseq_pkg::*; #(
	parameter int SAMPLE_CYCLES = SAMPLE_CYC_DEF,
	parameter int HIST_DEPTH = HIST_DEPTH_DEF,
	parameter int FW = 32
) (
	input wire logic REF_CLK_I,
	input wire logic RST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic PREADY_O,
	output logic [31:0] PRDATA_O,
	output logic PSLVERR_O,
	input wire logic HARD_RESET_N_PIN_I,
	input wire logic [1:0] SEL_PINS_I,
	input wire logic [3:0] CLK_VALID_I,
	input wire logic LOCK_DETECT_I,
	input wire logic [FW-1:0] FREQ_WORD_I,
	output logic OUT_ENABLE_O,
	output logic LOCK_LOST_N_PIN_O,
	output logic [1:0] MODE_O,
	output logic [1:0] INPUT_SEL_O,
	output logic [3:0] NBW_CODE_O,
	output logic [2:0] FBW_CODE_O,
	output logic FAST_ACTIVE_O,
	output logic XTAL_CAP_EN_O,
	output logic [3:0] IN_ENABLE_O,
	output logic [3:0] IN_DIFF_O,
	output logic [FW-1:0] HOLD_FREQ_O,
	output logic HOLD_APPLY_O
);
	localparam int AW = $clog2(HIST_DEPTH);
	localparam int SW = FW + 7;

	if (HIST_DEPTH < 2 || HIST_DEPTH > 127 || SAMPLE_CYCLES < 1 || FW < 1 || FW > 32) begin : g_chk
		$error("pmseq_top: unsupported parameter value");
	end

	logic [6:0] s1_reg, s2_reg, s3_reg, filt_reg;
	logic init_done_reg;
	logic [15:0] init_cnt_reg;
	logic hard_bit_reg, soft_pulse_reg, sel_reg_mode_reg, auto_reg, revert_reg;
	logic [1:0] sel_field_reg, cur_sel_reg, best_sel;
	logic [7:0] prio_reg;
	logic [2:0] win_reg;
	logic [6:0] delay_reg;
	pmseq_cfg_t cfg_pend_reg, cfg_app_reg;
	pmseq_state_t state_reg, state_next;
	logic hard_req, wr_en, mapped, best_found, sel_ok, hist_ok;
	logic [1:0] sel_next;
	logic [3:0] valid;
	logic [31:0] rdata;
	logic [FW-1:0] hist_mem [HIST_DEPTH];
	logic [AW-1:0] wptr_reg, rd_ptr_reg;
	logic [7:0] hist_cnt_reg, avg_left_reg;
	logic [31:0] samp_cnt_reg;
	logic avg_busy_reg;
	logic [SW-1:0] sum_reg, sum_next;
	logic [7:0] win_n;
	logic [8:0] rd_start;

	// Pins: three stages, a change counts once stages two and three agree
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			s1_reg <= SYNC_RST;
			s2_reg <= SYNC_RST;
			s3_reg <= SYNC_RST;
		end else begin
			s1_reg <= {HARD_RESET_N_PIN_I, SEL_PINS_I, CLK_VALID_I};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	for (genvar i = 0; i < 7; i++) begin : g_filt
		always_ff @(posedge REF_CLK_I or posedge RST_I) begin
			if (RST_I) begin
				filt_reg[i] <= SYNC_RST[i];
			end else if (s2_reg[i] == s3_reg[i]) begin
				filt_reg[i] <= s3_reg[i];
			end
		end
	end

	assign hard_req = ~filt_reg[6] | hard_bit_reg;

	// Initialization period, restarted by any hard reset
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			init_cnt_reg <= '0;
			init_done_reg <= 1'b0;
		end else if (hard_req) begin
			init_cnt_reg <= '0;
			init_done_reg <= 1'b0;
		end else if (!init_done_reg) begin
			if (init_cnt_reg == 16'(INIT_CYCLES - 1)) begin
				init_done_reg <= 1'b1;
			end else begin
				init_cnt_reg <= init_cnt_reg + 16'h0001;
			end
		end
	end

	// APB: bus stalls through init, so no write lands before the image is loaded
	assign PREADY_O = init_done_reg;
	assign wr_en = PSEL_I & PENABLE_I & PWRITE_I & init_done_reg;
	always_comb begin
		mapped = (PADDR_I[1:0] == 2'h0) && (PADDR_I <= OFS_HFREQ);
		PSLVERR_O = PSEL_I & PENABLE_I & init_done_reg & ~mapped;
	end

	// Register file; the hard reset reload also clears the hard reset bit itself
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			hard_bit_reg <= 1'b0;
			soft_pulse_reg <= 1'b0;
			sel_reg_mode_reg <= 1'b0;
			sel_field_reg <= '0;
			auto_reg <= 1'b0;
			revert_reg <= 1'b0;
			prio_reg <= NVM_PRIO;
			win_reg <= NVM_WIN;
			delay_reg <= NVM_DELAY;
			cfg_pend_reg <= NVM_CFG;
		end else if (hard_req) begin
			hard_bit_reg <= 1'b0;
			soft_pulse_reg <= 1'b0;
			sel_reg_mode_reg <= 1'b0;
			sel_field_reg <= '0;
			auto_reg <= 1'b0;
			revert_reg <= 1'b0;
			prio_reg <= NVM_PRIO;
			win_reg <= NVM_WIN;
			delay_reg <= NVM_DELAY;
			cfg_pend_reg <= NVM_CFG;
		end else begin
			soft_pulse_reg <= 1'b0;
			if (wr_en && mapped) begin
				case (PADDR_I)
					OFS_CTRL: begin
						hard_bit_reg <= PWDATA_I[B_HARD];
						soft_pulse_reg <= PWDATA_I[B_SOFT];
						cfg_pend_reg.fast_en <= PWDATA_I[B_FAST];
						cfg_pend_reg.ref_ext <= PWDATA_I[B_REFEXT];
						sel_reg_mode_reg <= PWDATA_I[B_SELREG];
						sel_field_reg <= PWDATA_I[B_SELLO +: 2];
						auto_reg <= PWDATA_I[B_AUTO];
						revert_reg <= PWDATA_I[B_REVERT];
					end
					OFS_BW: begin
						// Out of range codes saturate at the widest setting
						cfg_pend_reg.nbw <= (PWDATA_I[3:0] > NBW_MAX) ? NBW_MAX : PWDATA_I[3:0];
						cfg_pend_reg.fbw <= (PWDATA_I[6:4] > FBW_MAX) ? FBW_MAX : PWDATA_I[6:4];
					end
					OFS_INCFG: begin
						cfg_pend_reg.in_en <= PWDATA_I[3:0];
						cfg_pend_reg.in_diff <= PWDATA_I[7:4];
					end
					OFS_PRIO: prio_reg <= PWDATA_I[7:0];
					OFS_HOLD: begin
						win_reg <= (PWDATA_I[2:0] > WIN_LOG2_MAX) ? WIN_LOG2_MAX : PWDATA_I[2:0];
						delay_reg <= PWDATA_I[14:8];
					end
					default: ;
				endcase
			end
		end
	end

	// Pending configuration reaches the loop only through soft reset; init applies the nonvolatile image
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			cfg_app_reg <= NVM_CFG;
		end else if (hard_req || !init_done_reg) begin
			cfg_app_reg <= NVM_CFG;
		end else if (soft_pulse_reg) begin
			cfg_app_reg <= cfg_pend_reg;
		end
	end

	always_comb begin
		rdata = '0;
		case (PADDR_I)
			OFS_CTRL: rdata = {23'h0, revert_reg, auto_reg, sel_field_reg, sel_reg_mode_reg,
				cfg_pend_reg.ref_ext, cfg_pend_reg.fast_en, 1'b0, hard_bit_reg};
			OFS_BW: rdata = {25'h0, cfg_pend_reg.fbw, cfg_pend_reg.nbw};
			OFS_INCFG: rdata = {24'h0, cfg_pend_reg.in_diff, cfg_pend_reg.in_en};
			OFS_PRIO: rdata = {24'h0, prio_reg};
			OFS_HOLD: rdata = {17'h0, delay_reg, 5'h0, win_reg};
			OFS_STATUS: rdata = {22'h0, valid, cur_sel_reg, init_done_reg, ~LOCK_LOST_N_PIN_O, state_reg};
			OFS_HFREQ: rdata = 32'(HOLD_FREQ_O);
			default: rdata = '0;
		endcase
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			PRDATA_O <= '0;
		end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
			PRDATA_O <= rdata;
		end
	end

	// Input selection; a lower priority value wins, ties go to the lower index
	assign valid = filt_reg[3:0] & cfg_app_reg.in_en;
	always_comb begin
		best_found = 1'b0;
		best_sel = '0;
		for (int i = 0; i < 4; i++) begin
			if (valid[i] && (!best_found || prio_reg[2*i +: 2] < prio_reg[2*best_sel +: 2])) begin
				best_found = 1'b1;
				best_sel = 2'(i);
			end
		end
		if (!auto_reg) begin
			sel_next = sel_reg_mode_reg ? sel_field_reg : filt_reg[5:4];
		end else if (revert_reg || !valid[cur_sel_reg]) begin
			sel_next = best_found ? best_sel : cur_sel_reg;
		end else begin
			sel_next = cur_sel_reg;
		end
		sel_ok = valid[sel_next];
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			cur_sel_reg <= '0;
		end else begin
			cur_sel_reg <= sel_next;
		end
	end

	assign win_n = 8'h01 << win_reg;
	assign hist_ok = hist_cnt_reg >= (win_n + {1'b0, delay_reg});

	// Mode machine; without usable history a failed input falls back to free-run
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_FREERUN: if (sel_ok) state_next = ST_ACQUIRE;
			ST_ACQUIRE: begin
				if (!sel_ok) begin
					state_next = hist_ok ? ST_HOLDOVER : ST_FREERUN;
				end else if (LOCK_DETECT_I && sel_next == cur_sel_reg) begin
					state_next = ST_LOCKED;
				end
			end
			ST_LOCKED: begin
				if (!sel_ok) begin
					state_next = hist_ok ? ST_HOLDOVER : ST_FREERUN;
				end else if (sel_next != cur_sel_reg || !LOCK_DETECT_I) begin
					state_next = ST_ACQUIRE;
				end
			end
			ST_HOLDOVER: if (sel_ok) state_next = ST_ACQUIRE;
			default: state_next = ST_FREERUN;
		endcase
		if (!OUT_ENABLE_O) state_next = ST_FREERUN;
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			state_reg <= ST_FREERUN;
			LOCK_LOST_N_PIN_O <= 1'b0;
			FAST_ACTIVE_O <= 1'b0;
			OUT_ENABLE_O <= 1'b0;
		end else if (!init_done_reg || hard_req) begin
			state_reg <= ST_FREERUN;
			LOCK_LOST_N_PIN_O <= 1'b0;
			FAST_ACTIVE_O <= 1'b0;
			OUT_ENABLE_O <= 1'b0;
		end else begin
			state_reg <= state_next;
			LOCK_LOST_N_PIN_O <= (state_next == ST_LOCKED);
			FAST_ACTIVE_O <= cfg_app_reg.fast_en && (state_next == ST_ACQUIRE);
			OUT_ENABLE_O <= 1'b1;
		end
	end

	assign MODE_O = state_reg;
	assign INPUT_SEL_O = cur_sel_reg;
	assign NBW_CODE_O = cfg_app_reg.nbw;
	assign FBW_CODE_O = cfg_app_reg.fbw;
	assign XTAL_CAP_EN_O = ~cfg_app_reg.ref_ext;
	assign IN_ENABLE_O = cfg_app_reg.in_en;
	assign IN_DIFF_O = cfg_app_reg.in_diff;

	// History ring, one sample per period while locked
	always_ff @(posedge REF_CLK_I) begin
		if (state_reg == ST_LOCKED && samp_cnt_reg == 32'(SAMPLE_CYCLES - 1)) begin
			hist_mem[wptr_reg] <= FREQ_WORD_I;
		end
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			samp_cnt_reg <= '0;
			wptr_reg <= '0;
			hist_cnt_reg <= '0;
		end else if (hard_req) begin
			samp_cnt_reg <= '0;
			wptr_reg <= '0;
			hist_cnt_reg <= '0;
		end else if (state_reg != ST_LOCKED) begin
			samp_cnt_reg <= '0;
		end else if (samp_cnt_reg == 32'(SAMPLE_CYCLES - 1)) begin
			samp_cnt_reg <= '0;
			wptr_reg <= (wptr_reg == AW'(HIST_DEPTH - 1)) ? '0 : wptr_reg + AW'(1);
			if (hist_cnt_reg != 8'(HIST_DEPTH)) begin
				hist_cnt_reg <= hist_cnt_reg + 8'h01;
			end
		end else begin
			samp_cnt_reg <= samp_cnt_reg + 32'h0000_0001;
		end
	end

	// Average walks backwards from the newest sample, skipping the delay
	assign rd_start = 9'(wptr_reg) + 9'(HIST_DEPTH - 1) - 9'(delay_reg);
	assign sum_next = sum_reg + SW'(hist_mem[rd_ptr_reg]);

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			avg_busy_reg <= 1'b0;
			avg_left_reg <= '0;
			rd_ptr_reg <= '0;
			sum_reg <= '0;
			HOLD_FREQ_O <= '0;
			HOLD_APPLY_O <= 1'b0;
		end else begin
			HOLD_APPLY_O <= 1'b0;
			if (state_reg != ST_HOLDOVER && state_next == ST_HOLDOVER && init_done_reg && !hard_req) begin
				avg_busy_reg <= 1'b1;
				avg_left_reg <= win_n;
				sum_reg <= '0;
				rd_ptr_reg <= AW'((rd_start >= 9'(HIST_DEPTH)) ? rd_start - 9'(HIST_DEPTH) : rd_start);
			end else if (avg_busy_reg) begin
				sum_reg <= sum_next;
				avg_left_reg <= avg_left_reg - 8'h01;
				rd_ptr_reg <= (rd_ptr_reg == '0) ? AW'(HIST_DEPTH - 1) : rd_ptr_reg - AW'(1);
				if (avg_left_reg == 8'h01) begin
					avg_busy_reg <= 1'b0;
					HOLD_FREQ_O <= FW'(sum_next >> win_reg);
					HOLD_APPLY_O <= 1'b1;
				end
			end
		end
	end

	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (RST_I);

	sequence lock_to_hold_s;
		state_reg == ST_LOCKED ##1 state_reg == ST_HOLDOVER;
	endsequence

	out_gate_a: assert property (!init_done_reg |=> !OUT_ENABLE_O) else $error("outputs on during init");
	bus_stall_a: assert property (!init_done_reg |-> !PREADY_O) else $error("bus answered during init");
	freerun_entry_a: assert property ($rose(OUT_ENABLE_O) |-> state_reg == ST_FREERUN) else $error("bad first mode");
	lock_pin_a: assert property ((state_reg == ST_LOCKED) == LOCK_LOST_N_PIN_O) else $error("lock pin mismatch");
	fast_bw_a: assert property (FAST_ACTIVE_O |-> state_reg == ST_ACQUIRE) else $error("fast bw outside acquire");
	acquire_start_a: assert property (state_reg == ST_FREERUN && sel_ok && init_done_reg && !hard_req && OUT_ENABLE_O
		|=> state_reg == ST_ACQUIRE) else $error("acquire not started");
	hold_avg_a: assert property (lock_to_hold_s |-> ##[0:70] HOLD_APPLY_O) else $error("holdover average missing");
	hard_clear_a: assert property (hard_bit_reg |=> !hard_bit_reg && !init_done_reg) else $error("hard bit stuck");
	pin_select_a: assert property (!auto_reg && !sel_reg_mode_reg |=> INPUT_SEL_O == $past(filt_reg[5:4]))
		else $error("pin selection ignored");
	revert_sel_a: assert property (auto_reg && revert_reg && |valid |=> INPUT_SEL_O == $past(best_sel))
		else $error("best input not chosen");
endmodule

// ---- dv/pmseq_ref_model.sv ----
// Model of the reference inputs and the loop lock detector
`timescale 1ns/100ps
module pmseq_ref_model import pmseq_pkg::*; #(
	parameter logic [31:0] BASE = 32'h1234_5678
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [1:0] mode_i,
	input wire logic [1:0] sel_i,
	input wire logic [3:0] valid_i,
	input wire logic [7:0] wait_i,
	input wire logic bad_i,
	output logic [3:0] valid_o,
	output logic lock_o,
	output logic [31:0] freq_o
);
	logic [7:0] cnt;
	logic [1:0] sel_q;
	// Pull-in restarts whenever the selection moves
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt <= 8'h00;
			sel_q <= 2'h0;
		end else begin
			sel_q <= sel_i;
			if (mode_i == ST_FREERUN || mode_i == ST_HOLDOVER || sel_i != sel_q) begin
				cnt <= 8'h00;
			end else if (cnt != 8'hFF) begin
				cnt <= cnt + 8'h01;
			end
		end
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			valid_o <= 4'h0;
			lock_o <= 1'h0;
			freq_o <= 32'h0;
		end else begin
			valid_o <= valid_i;
			lock_o <= cnt >= wait_i && (mode_i == ST_ACQUIRE || mode_i == ST_LOCKED);
			// Outside lock the word wanders, so stale history cannot pass
			freq_o <= mode_i == ST_LOCKED ? (bad_i ? ~BASE : BASE) : freq_o + 32'h0101_0101;
		end
	end
endmodule

// ---- dv/pmseq_top_tb.sv ----
// Self-checking bench of the clock loop mode sequencer
`timescale 1ns/100ps
module pmseq_top_tb import pmseq_pkg::*; ();
	localparam logic [31:0] BASE = 32'h1234_5678;
	logic clk, rst, psel, pen, pwr, hard_n, bad, pready, pslverr, lock, out_en, lol_n, fast, xcap, happly, err;
	logic [7:0] paddr, lwait;
	logic [31:0] pwdata, prdata, freq, hfreq, q;
	logic [1:0] sel_pins, mode, isel;
	logic [3:0] vmask, valid, nbw, in_en, in_diff;
	logic [2:0] fbw;
	int mismatches = 0;
	int comparisons = 0;
	int cycles = 0;

	pmseq_top #(.SAMPLE_CYCLES(4)) DUT (.REF_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready), .PRDATA_O(prdata),
		.PSLVERR_O(pslverr), .HARD_RESET_N_PIN_I(hard_n), .SEL_PINS_I(sel_pins), .CLK_VALID_I(valid),
		.LOCK_DETECT_I(lock), .FREQ_WORD_I(freq), .OUT_ENABLE_O(out_en), .LOCK_LOST_N_PIN_O(lol_n),
		.MODE_O(mode), .INPUT_SEL_O(isel), .NBW_CODE_O(nbw), .FBW_CODE_O(fbw), .FAST_ACTIVE_O(fast),
		.XTAL_CAP_EN_O(xcap), .IN_ENABLE_O(in_en), .IN_DIFF_O(in_diff), .HOLD_FREQ_O(hfreq),
		.HOLD_APPLY_O(happly));
	pmseq_ref_model #(.BASE(BASE)) partner (.clk_i(clk), .rst_i(rst), .mode_i(mode), .sel_i(isel),
		.valid_i(vmask), .wait_i(lwait), .bad_i(bad), .valid_o(valid), .lock_o(lock), .freq_o(freq));

	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 12000) begin
			mismatches++;
			finish_test();
		end
	end

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Entered just after a rising edge; leaves one idle cycle behind
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwr <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'h1;
		@(posedge clk);
		while (pready !== 1'h1) @(posedge clk);
		q = prdata;
		err = pslverr;
		psel <= 1'h0;
		pen <= 1'h0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		apb(1'h0, a, 32'h0);
		check(what, exp, q);
		check({what, " err"}, 0, err);
	endtask

	task automatic wait_mode(input pmseq_state_t m);
		int n;
		n = 0;
		while (mode !== m && n < 40) begin
			@(posedge clk);
			n++;
		end
		check("mode", m, mode);
	endtask

	task automatic wait_ready();
		int n;
		n = 0;
		while (pready !== 1'h1 && n < 1100) begin
			@(posedge clk);
			n++;
		end
		check("pready", 1, pready);
		tick(2);
		check("out_en", 1, out_en);
		check("mode", ST_FREERUN, mode);
	endtask

	task automatic defaults();
		rd(OFS_BW, 32'h23, "bw");
		rd(OFS_INCFG, 32'hFF, "incfg");
		rd(OFS_PRIO, 32'hE4, "prio");
		rd(OFS_HOLD, 32'h0203, "hold");
		rd(OFS_CTRL, 32'h04, "ctrl");
		check("nbw", NVM_NBW, nbw);
		check("fbw", NVM_FBW, fbw);
		check("xcap", 1, xcap);
		check("in_en", 32'hF, in_en);
	endtask

	initial begin
		{rst, hard_n} = 2'h3;
		{psel, pen, pwr, bad} = 4'h0;
		{paddr, pwdata, sel_pins, vmask} = '0;
		lwait = 8'h05;
		tick(16);
		rst <= 1'h0;
		tick(10);
		check("pready", 0, pready);
		check("out_en", 0, out_en);
		wait_ready();
		defaults();
		apb(1'h0, 8'h1C, 32'h0);
		check("unmapped err", 1, err);
		check("unmapped data", 0, q);
		apb(1'h1, 8'h02, 32'h0);
		check("misaligned", 1, err);
		apb(1'h1, OFS_BW, 32'hFF);
		rd(OFS_BW, 32'h59, "bw sat");
		check("nbw pending", NVM_NBW, nbw);
		apb(1'h1, OFS_INCFG, 32'h3E);
		apb(1'h1, OFS_CTRL, 32'h0E);
		tick(3);
		check("nbw", 9, nbw);
		check("fbw", 5, fbw);
		check("in cfg", 32'h3E, {in_diff, in_en});
		check("xcap", 0, xcap);
		check("no init", 2'h3, {pready, out_en});
		rd(OFS_BW, 32'h59, "bw kept");
		sel_pins <= 2'h1;
		vmask <= 4'h2;
		wait_mode(ST_ACQUIRE);
		check("sel", 1, isel);
		check("fast", 1, fast);
		check("lol_n", 0, lol_n);
		wait_mode(ST_LOCKED);
		check("lol_n", 1, lol_n);
		check("fast", 0, fast);
		apb(1'h0, OFS_STATUS, 32'h0);
		check("status", 32'h2, q & 32'h7);
		tick(100);
		bad <= 1'h1;
		tick(1);
		vmask <= 4'h0;
		wait_mode(ST_HOLDOVER);
		for (int n = 0; n < 60 && happly !== 1'h1; n++) @(posedge clk);
		check("hold apply", 1, happly);
		check("hold freq", BASE, hfreq);
		rd(OFS_HFREQ, BASE, "hfreq reg");
		bad <= 1'h0;
		lwait <= 8'h28;
		vmask <= 4'h2;
		wait_mode(ST_ACQUIRE);
		tick(20);
		check("lol_n slow", 0, lol_n);
		wait_mode(ST_LOCKED);
		apb(1'h1, OFS_CTRL, 32'h184);
		vmask <= 4'hC;
		tick(12);
		check("auto sel", 2, isel);
		vmask <= 4'hF;
		tick(12);
		check("revert sel", 1, isel);
		apb(1'h1, OFS_CTRL, 32'h084);
		vmask <= 4'hC;
		tick(12);
		vmask <= 4'hE;
		tick(12);
		check("keep sel", 2, isel);
		apb(1'h1, OFS_CTRL, 32'h074);
		tick(12);
		check("reg sel", 3, isel);
		vmask <= 4'h0;
		apb(1'h1, OFS_BW, 32'h11);
		apb(1'h1, OFS_CTRL, 32'h01);
		tick(3);
		check("hard busy", 2'h0, {pready, out_en});
		wait_ready();
		defaults();
		apb(1'h1, OFS_BW, 32'h11);
		hard_n <= 1'h0;
		tick(8);
		check("pin busy", 2'h0, {pready, out_en});
		hard_n <= 1'h1;
		wait_ready();
		defaults();
		apb(1'h1, OFS_CTRL, 32'h02);
		tick(3);
		vmask <= 4'h2;
		wait_mode(ST_ACQUIRE);
		check("fast off", 0, fast);
		finish_test();
	end
endmodule
